// ===== hw/dbp_host.v
// host controller driving the sixteen-channel double-buffered converter port
`include "dbp_host_regs.vh"
module dbp_host #(
  parameter [7:0] LOW_CYC  = `DBP_STROBE_LOW_CYC,
  parameter [7:0] HIGH_CYC = `DBP_STROBE_HIGH_CYC,
  parameter [7:0] HOLD_CYC = `DBP_DATA_HOLD_CYC,
  parameter [7:0] READ_CYC = `DBP_READ_WAIT_CYC
) (
  input  wire        aclk,
  input  wire        aresetn,
  input  wire [3:0]  s_axi_awaddr,
  input  wire        s_axi_awvalid,
  output reg         s_axi_awready,
  input  wire [31:0] s_axi_wdata,
  input  wire [3:0]  s_axi_wstrb,
  input  wire        s_axi_wvalid,
  output reg         s_axi_wready,
  output reg  [1:0]  s_axi_bresp,
  output reg         s_axi_bvalid,
  input  wire        s_axi_bready,
  input  wire [3:0]  s_axi_araddr,
  input  wire        s_axi_arvalid,
  output reg         s_axi_arready,
  output reg  [31:0] s_axi_rdata,
  output reg  [1:0]  s_axi_rresp,
  output reg         s_axi_rvalid,
  input  wire        s_axi_rready,
  output reg  [3:0]  channel_select,
  input  wire [7:0]  data_pins_in,
  output reg  [7:0]  data_pins_out,
  output reg         data_pins_oe,
  output reg         chip_select_n,
  output reg         read_write,
  output reg         write_strobe_n,
  output reg         transfer_strobe_n,
  output reg         clear_n
);
  // ----------------------------------------------------------------
  // state encoding
  // ----------------------------------------------------------------
  localparam [2:0] ST_IDLE   = 3'h0;
  localparam [2:0] ST_W_LOW  = 3'h1;
  localparam [2:0] ST_W_HOLD = 3'h2;
  localparam [2:0] ST_T_LOW  = 3'h3;
  localparam [2:0] ST_R_WAIT = 3'h4;
  localparam [2:0] ST_R_CAP  = 3'h5;
  localparam [2:0] ST_GAP    = 3'h6;
  localparam [7:0] SYNC_CYC  = 8'h03;

  reg  [2:0]  state;
  reg  [7:0]  count;
  reg  [13:0] command;
  reg         cfg_clear;
  reg  [7:0]  read_data;
  reg  [7:0]  sync1;
  reg  [7:0]  sync2;
  reg  [7:0]  sync3;
  reg         aw_held;
  reg         w_held;
  reg  [3:0]  aw_addr;
  reg  [31:0] w_data;
  reg  [3:0]  w_strb;
  reg         start;
  reg  [1:0]  start_op;
  wire        busy = (state != ST_IDLE) | start;
  wire        do_write = aw_held & w_held & ~s_axi_bvalid;

  function mapped;
    input [3:0] addr;
    begin
      mapped = (addr == `DBP_ADDR_COMMAND) | (addr == `DBP_ADDR_STATUS) |
               (addr == `DBP_ADDR_CONFIG);
    end
  endfunction

  // ----------------------------------------------------------------
  // axi4-lite write path
  // ----------------------------------------------------------------
  always @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_awready <= 1'b0;
      s_axi_wready  <= 1'b0;
      s_axi_bvalid  <= 1'b0;
      s_axi_bresp   <= 2'h0;
      aw_held       <= 1'b0;
      w_held        <= 1'b0;
      aw_addr       <= 4'h0;
      w_data        <= 32'h0;
      w_strb        <= 4'h0;
      command       <= `DBP_RESET_COMMAND;
      cfg_clear     <= `DBP_RESET_CONFIG;
      start         <= 1'b0;
      start_op      <= `DBP_OP_NONE;
    end else begin
      start         <= 1'b0;
      s_axi_awready <= ~aw_held & ~(s_axi_awvalid & s_axi_awready);
      s_axi_wready  <= ~w_held & ~(s_axi_wvalid & s_axi_wready);
      if (s_axi_awvalid & s_axi_awready) begin
        aw_held <= 1'b1;
        aw_addr <= s_axi_awaddr;
      end
      if (s_axi_wvalid & s_axi_wready) begin
        w_held <= 1'b1;
        w_data <= s_axi_wdata;
        w_strb <= s_axi_wstrb;
      end
      if (do_write) begin
        s_axi_bvalid <= 1'b1;
        s_axi_bresp  <= 2'h0;
        if (!mapped(aw_addr) || (aw_addr == `DBP_ADDR_COMMAND && busy)) begin
          s_axi_bresp <= 2'h2;
        end else if (aw_addr == `DBP_ADDR_COMMAND && w_strb[1:0] == 2'h3) begin
          command  <= w_data[13:0];
          start    <= 1'b1;
          start_op <= w_data[`DBP_CMD_OP_LSB +: 2];
        end else if (aw_addr == `DBP_ADDR_CONFIG && w_strb[0]) begin
          cfg_clear <= w_data[`DBP_CFG_CLEAR_BIT];
        end
      end
      if (s_axi_bvalid & s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
        aw_held      <= 1'b0;
        w_held       <= 1'b0;
      end
    end
  end

  // ----------------------------------------------------------------
  // axi4-lite read path
  // ----------------------------------------------------------------
  always @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid  <= 1'b0;
      s_axi_rdata   <= 32'h0;
      s_axi_rresp   <= 2'h0;
    end else begin
      s_axi_arready <= ~s_axi_rvalid & ~(s_axi_arvalid & s_axi_arready);
      if (s_axi_arvalid & s_axi_arready) begin
        s_axi_rvalid <= 1'b1;
        s_axi_rresp  <= mapped(s_axi_araddr) ? 2'h0 : 2'h2;
        case (s_axi_araddr)
          `DBP_ADDR_COMMAND: s_axi_rdata <= {18'h0, command};
          `DBP_ADDR_STATUS:  s_axi_rdata <= {16'h0, read_data, 7'h0, busy};
          `DBP_ADDR_CONFIG:  s_axi_rdata <= {31'h0, cfg_clear};
          default:           s_axi_rdata <= 32'h0;
        endcase
      end else if (s_axi_rvalid & s_axi_rready) begin
        s_axi_rvalid <= 1'b0;
      end
    end
  end

  // ----------------------------------------------------------------
  // readback synchroniser
  // ----------------------------------------------------------------
  always @(posedge aclk) begin
    if (!aresetn) begin
      sync1 <= 8'h00;
      sync2 <= 8'h00;
      sync3 <= 8'h00;
    end else begin
      sync1 <= data_pins_in;
      sync2 <= sync1;
      sync3 <= sync2;
    end
  end

  // ----------------------------------------------------------------
  // pin sequencer
  // ----------------------------------------------------------------
  always @(posedge aclk) begin
    if (!aresetn) begin
      state             <= ST_IDLE;
      count             <= 8'h00;
      read_data         <= 8'h00;
      channel_select    <= 4'h0;
      data_pins_out     <= 8'h00;
      data_pins_oe      <= 1'b1;
      chip_select_n     <= 1'b1;
      read_write        <= 1'b1;
      write_strobe_n    <= 1'b1;
      transfer_strobe_n <= 1'b1;
      clear_n           <= 1'b0;
    end else begin
      clear_n <= ~cfg_clear;
      case (state)
        ST_IDLE: begin
          if (start) begin
            channel_select <= command[`DBP_CMD_CHAN_LSB +: 4];
            case (start_op)
              `DBP_OP_WRITE: begin
                // address, data and strobe fall together
                data_pins_out  <= command[`DBP_CMD_DATA_LSB +: 8];
                data_pins_oe   <= 1'b0;
                read_write     <= 1'b0;
                chip_select_n  <= 1'b0;
                write_strobe_n <= 1'b0;
                count          <= LOW_CYC - 8'h01;
                state          <= ST_W_LOW;
              end
              `DBP_OP_READ: begin
                data_pins_oe      <= 1'b1;
                read_write        <= 1'b1;
                chip_select_n     <= 1'b0;
                write_strobe_n    <= 1'b1;
                transfer_strobe_n <= 1'b1;
                count             <= READ_CYC + SYNC_CYC;
                state             <= ST_R_WAIT;
              end
              `DBP_OP_TRANSFER: begin
                chip_select_n     <= 1'b1;
                write_strobe_n    <= 1'b0;
                transfer_strobe_n <= 1'b0;
                count             <= LOW_CYC - 8'h01;
                state             <= ST_T_LOW;
              end
              default: state <= ST_IDLE;
            endcase
          end
        end
        ST_W_LOW: begin
          if (count == 8'h00) begin
            write_strobe_n <= 1'b1;
            count          <= HOLD_CYC - 8'h01;
            state          <= ST_W_HOLD;
          end else begin
            count <= count - 8'h01;
          end
        end
        ST_W_HOLD: begin
          if (count == 8'h00) begin
            chip_select_n <= 1'b1;
            data_pins_oe  <= 1'b1;
            count         <= HIGH_CYC - 8'h01;
            state         <= ST_GAP;
          end else begin
            count <= count - 8'h01;
          end
        end
        ST_T_LOW: begin
          if (count == 8'h00) begin
            write_strobe_n    <= 1'b1;
            transfer_strobe_n <= 1'b1;
            count             <= HIGH_CYC - 8'h01;
            state             <= ST_GAP;
          end else begin
            count <= count - 8'h01;
          end
        end
        ST_R_WAIT: begin
          if (count == 8'h00) begin
            state <= ST_R_CAP;
          end else begin
            count <= count - 8'h01;
          end
        end
        ST_R_CAP: begin
          if (sync2 == sync3) begin
            read_data     <= sync3;
            chip_select_n <= 1'b1;
            count         <= HIGH_CYC - 8'h01;
            state         <= ST_GAP;
          end
        end
        ST_GAP: begin
          // strobe high time keeps the strobe period legal
          if (count == 8'h00) begin
            state <= ST_IDLE;
          end else begin
            count <= count - 8'h01;
          end
        end
        default: state <= ST_IDLE;
      endcase
    end
  end
endmodule

// ===== hw/dbp_host_regs.vh
// register map, field positions and timing counts of the converter port controller
// Overview of operation
// - host pulses write strobe per channel, changing address as strobe falls
// - host keeps data valid setup before and hold after strobe rise
// - write strobe low plus high time at least 80 ns
// - host keeps chip select high during a transfer
// - single channel update is one load followed by one transfer
// - readback uses read/write high, chip select low, strobes high
`ifndef DBP_HOST_REGS_VH
`define DBP_HOST_REGS_VH
`define DBP_ADDR_COMMAND      4'h0
`define DBP_ADDR_STATUS       4'h4
`define DBP_ADDR_CONFIG       4'h8
`define DBP_CMD_DATA_LSB      0
`define DBP_CMD_CHAN_LSB      8
`define DBP_CMD_OP_LSB        12
`define DBP_OP_NONE           2'h0
`define DBP_OP_WRITE          2'h1
`define DBP_OP_READ           2'h2
`define DBP_OP_TRANSFER       2'h3
`define DBP_STAT_BUSY_BIT     0
`define DBP_STAT_DATA_LSB     8
`define DBP_CFG_CLEAR_BIT     0
`define DBP_RESET_COMMAND     14'h0000
`define DBP_RESET_CONFIG      1'h0
`define DBP_CLK_NS            10
`define DBP_STROBE_LOW_NS     40
`define DBP_STROBE_HIGH_NS    40
`define DBP_DATA_HOLD_NS      10
`define DBP_READ_WAIT_NS      200
`define DBP_CYC(ns)           (((ns) + `DBP_CLK_NS - 1) / `DBP_CLK_NS)
`define DBP_STROBE_LOW_CYC    `DBP_CYC(`DBP_STROBE_LOW_NS)
`define DBP_STROBE_HIGH_CYC   `DBP_CYC(`DBP_STROBE_HIGH_NS)
`define DBP_DATA_HOLD_CYC     `DBP_CYC(`DBP_DATA_HOLD_NS)
`define DBP_READ_WAIT_CYC     `DBP_CYC(`DBP_READ_WAIT_NS)
`endif

// ===== verif/dbp_dev_model.sv
// behavioural model of the sixteen-channel latch-based converter port
module dbp_dev_model #(
  parameter int DRIVE_DLY = 3,
  parameter int VALID_DLY = 5
) (
  input  logic       aclk,
  input  logic       cs_n,
  input  logic       rw,
  input  logic       we_n,
  input  logic       xfer_n,
  input  logic       clr_n,
  input  logic [3:0] ch,
  input  logic [7:0] bus,
  output logic       dr_en,
  output logic [7:0] dr
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [7:0] inreg [16];
  logic [7:0] outreg [16];
  logic [3:0] lch;
  int         rc, ac;
  always_latch if (!cs_n && !rw && !we_n) inreg[ch] = bus;
  always_latch begin
    for (int i = 0; i < 16; i++) begin
      if (!clr_n) outreg[i] = 8'h00;
      else if (!xfer_n && !we_n) outreg[i] = inreg[i];
    end
  end
  always @(posedge aclk) begin
    rc <= (!cs_n && rw) ? rc + 1 : 0;
    ac <= (ch != lch) ? 0 : ac + 1;
    lch <= ch;
  end
  assign dr_en = !cs_n && rw && we_n && xfer_n && rc >= DRIVE_DLY;
  assign dr = (ac >= VALID_DLY) ? inreg[ch] : ~inreg[ch];
endmodule

// ===== verif/dbp_host_properties.sv
// pin and bus timing checks on the converter port controller
module dbp_host_properties (
  input logic        aclk,
  input logic        aresetn,
  input logic        s_axi_bvalid,
  input logic        s_axi_bready,
  input logic        s_axi_rvalid,
  input logic        s_axi_rready,
  input logic        data_pins_oe,
  input logic        chip_select_n,
  input logic        read_write,
  input logic        write_strobe_n,
  input logic        transfer_strobe_n,
  input logic [1:0]  s_axi_bresp,
  input logic [31:0] s_axi_rdata,
  input logic [7:0]  data_pins_out
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  a_low_time: assert property ($fell(write_strobe_n) |-> !write_strobe_n [*4])
    else $error("strobe low too short");
  a_high_time: assert property ($rose(write_strobe_n) |-> write_strobe_n [*4])
    else $error("strobe high too short");
  // data still driven and unchanged in the cycle after the strobe rises
  a_hold_data: assert property ($rose(write_strobe_n) && !chip_select_n
    |-> !data_pins_oe && $stable(data_pins_out)) else $error("data hold lost");
  a_xfer_cs_high: assert property (!transfer_strobe_n |-> chip_select_n)
    else $error("select low in transfer");
  a_xfer_we_low: assert property (!transfer_strobe_n |-> !write_strobe_n)
    else $error("transfer without strobe");
  a_read_quiet: assert property ((!chip_select_n && read_write)
    |-> write_strobe_n && transfer_strobe_n && data_pins_oe) else $error("bad read");
  a_write_setup: assert property ($fell(write_strobe_n) && transfer_strobe_n
    |-> !chip_select_n && !read_write && !data_pins_oe) else $error("bad write");
  a_cs_release: assert property ($rose(chip_select_n) |-> data_pins_oe)
    else $error("pins driven after deselect");
  a_b_hold: assert property (s_axi_bvalid && !s_axi_bready
    |=> s_axi_bvalid && $stable(s_axi_bresp)) else $error("response dropped");
  a_r_hold: assert property (s_axi_rvalid && !s_axi_rready
    |=> s_axi_rvalid && $stable(s_axi_rdata)) else $error("read data dropped");
  c_write: cover property ($fell(write_strobe_n) && transfer_strobe_n);
  c_xfer: cover property ($fell(transfer_strobe_n));
  c_read: cover property ($fell(chip_select_n) && read_write);
endmodule
bind dbp_host dbp_host_properties u_chk (
  .aclk              (aclk),
  .aresetn           (aresetn),
  .s_axi_bvalid      (s_axi_bvalid),
  .s_axi_bready      (s_axi_bready),
  .s_axi_rvalid      (s_axi_rvalid),
  .s_axi_rready      (s_axi_rready),
  .data_pins_oe      (data_pins_oe),
  .chip_select_n     (chip_select_n),
  .read_write        (read_write),
  .write_strobe_n    (write_strobe_n),
  .transfer_strobe_n (transfer_strobe_n),
  .s_axi_bresp       (s_axi_bresp),
  .s_axi_rdata       (s_axi_rdata),
  .data_pins_out     (data_pins_out)
);

// ===== verif/tb_top.sv
// self-checking bench for the converter port controller
module tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  logic        aclk = 0, aresetn = 0;
  logic [3:0]  s_axi_awaddr = 0, s_axi_wstrb = 4'hf, s_axi_araddr = 0;
  logic [31:0] s_axi_wdata = 0, v;
  logic        s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0;
  logic        s_axi_arvalid = 0, s_axi_rready = 0;
  logic        s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic [1:0]  s_axi_bresp, s_axi_rresp, r;
  logic [31:0] s_axi_rdata;
  logic [3:0]  channel_select;
  logic [7:0]  data_pins_out, dr, bus, pat = 8'h55;
  logic        data_pins_oe, chip_select_n, read_write, write_strobe_n;
  logic        transfer_strobe_n, clear_n, dr_en;
  logic [11:0] rows [4] = '{12'h000, 12'hfff, 12'h580, 12'ha7f};
  int          n_fail = 0, n_tests = 0;
  always #5 aclk = ~aclk;
  // a released bus shows a changing pattern, never the last value
  always @(posedge aclk) pat <= ~pat;
  assign bus = !data_pins_oe ? data_pins_out : dr_en ? dr : pat;
  dbp_host DUT (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(s_axi_awaddr),
    .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
    .s_axi_wdata(s_axi_wdata), .s_axi_wstrb(s_axi_wstrb), .s_axi_wvalid(s_axi_wvalid),
    .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid),
    .s_axi_bready(s_axi_bready), .s_axi_araddr(s_axi_araddr),
    .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
    .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid),
    .s_axi_rready(s_axi_rready), .channel_select(channel_select), .data_pins_in(bus),
    .data_pins_out(data_pins_out), .data_pins_oe(data_pins_oe),
    .chip_select_n(chip_select_n), .read_write(read_write),
    .write_strobe_n(write_strobe_n), .transfer_strobe_n(transfer_strobe_n),
    .clear_n(clear_n));
  dbp_dev_model u_dev (.aclk(aclk), .cs_n(chip_select_n), .rw(read_write),
    .we_n(write_strobe_n), .xfer_n(transfer_strobe_n), .clr_n(clear_n),
    .ch(channel_select), .bus(bus), .dr_en(dr_en), .dr(dr));
  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    n_tests++;
    if (g !== e) begin
      n_fail++;
      $display("[FAIL] %0t got %h expected %h", $time, g, e);
    end
  endtask
  task automatic wr(input logic [3:0] a, input logic [31:0] d, output logic [1:0] resp);
    logic aw, w;
    aw = 0;
    w = 0;
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1;
    s_axi_wvalid <= 1;
    while (!(aw && w)) begin
      @(posedge aclk);
      if (s_axi_awvalid && s_axi_awready) begin
        aw = 1;
        s_axi_awvalid <= 0;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w = 1;
        s_axi_wvalid <= 0;
      end
    end
    s_axi_bready <= 1;
    do @(posedge aclk); while (!s_axi_bvalid);
    resp = s_axi_bresp;
    s_axi_bready <= 0;
  endtask
  task automatic rd(input logic [3:0] a, output logic [31:0] d, output logic [1:0] resp);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1;
    do @(posedge aclk); while (!s_axi_arready);
    s_axi_arvalid <= 0;
    s_axi_rready <= 1;
    do @(posedge aclk); while (!s_axi_rvalid);
    d = s_axi_rdata;
    resp = s_axi_rresp;
    s_axi_rready <= 0;
  endtask
  // issue a command and poll until the controller is idle again
  task automatic op(input logic [31:0] c);
    wr(4'h0, c, r);
    do rd(4'h4, v, r); while (v[0] !== 1'b0);
  endtask
  task wrap_up;
    if (n_fail == 0 && n_tests > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  initial begin
    #500us;
    n_fail++;
    wrap_up;
  end
  initial begin
    repeat (16) @(posedge aclk);
    aresetn <= 1;
    @(posedge aclk);
    rd(4'h4, v, r);
    chk(v, 32'h0);
    rd(4'h8, v, r);
    chk(v, 32'h0);
    foreach (rows[i]) begin
      op({20'h1, rows[i]});
      op({20'h2, rows[i][11:8], 8'h00});
      rd(4'h4, v, r);
      chk(v, {16'h0, rows[i][7:0], 8'h00});
      chk(u_dev.inreg[rows[i][11:8]], rows[i][7:0]);
    end
    op(32'h3000);
    foreach (rows[i]) chk(u_dev.outreg[rows[i][11:8]], rows[i][7:0]);
    op(32'h1533);
    // reading another channel crosses the address-to-valid hold-off
    op(32'h2a00);
    rd(4'h4, v, r);
    chk(v, 32'h00007f00);
    op(32'h3000);
    chk(u_dev.outreg[5], 8'h33);
    chk(u_dev.outreg[10], 8'h7f);
    wr(4'h8, 32'h1, r);
    repeat (2) @(posedge aclk);
    for (int i = 0; i < 16; i++) chk(u_dev.outreg[i], 8'h00);
    wr(4'h8, 32'h0, r);
    wr(4'hc, 32'h1, r);
    chk(r, 2'h2);
    rd(4'hc, v, r);
    chk(r, 2'h2);
    chk(v, 32'h0);
    // a command while the previous one runs is refused and leaves no trace
    wr(4'h0, 32'h1144, r);
    chk(r, 2'h0);
    wr(4'h0, 32'h1566, r);
    chk(r, 2'h2);
    do rd(4'h4, v, r); while (v[0] !== 1'b0);
    chk(u_dev.inreg[1], 8'h44);
    chk(u_dev.inreg[5], 8'h33);
    op(32'h0);
    op(32'h3000);
    chk(u_dev.outreg[5], 8'h33);
    // reset after the last transfer has finished clears the outputs and the readback register
    aresetn <= 0;
    repeat (2) @(posedge aclk);
    chk(clear_n, 1'b0);
    chk(u_dev.outreg[5], 8'h00);
    aresetn <= 1;
    @(posedge aclk);
    rd(4'h4, v, r);
    chk(v, 32'h0);
    chk(clear_n, 1'b1);
    wrap_up;
  end
endmodule
